/* File: logic/tmc_edge_det.sv */
`timescale 1ns/10ps
module tmc_edge_det
  import tmc_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire logic      ce,
  input  wire logic      level,
  input  wire tmc_edge_t sel,
  output logic           hit
);

  typedef struct packed {
    logic prev;
  } tmc_edge_state_t;

  tmc_edge_state_t state_q;
  tmc_edge_state_t state_d;

  always_comb begin
    state_d      = state_q;
    state_d.prev = level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_comb begin
    unique case (sel)
      EDGE_NONE: hit = 1'b0;
      EDGE_RISE: hit = level & ~state_q.prev;
      EDGE_FALL: hit = ~level & state_q.prev;
      EDGE_BOTH: hit = level ^ state_q.prev;
    endcase
  end

endmodule

/* File: logic/tmc_pkg.sv */
package tmc_pkg;

  typedef enum logic [2:0] {
    MODE_INTERVAL    = 3'b000,
    MODE_EVENT_COUNT = 3'b001,
    MODE_EXT_TRIG    = 3'b010,
    MODE_ONE_SHOT    = 3'b011,
    MODE_PWM         = 3'b100,
    MODE_FREE_RUN    = 3'b101,
    MODE_PULSE_WIDTH = 3'b110,
    MODE_PROHIBITED  = 3'b111
  } tmc_mode_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } tmc_edge_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } tmc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tmc_axi_rsp_t;

  // register indices; byte address is four times the index
  localparam logic [31:0] IDX_RUN_CTL   = 32'hfffff590;
  localparam logic [31:0] IDX_MODE_CTL  = 32'hfffff591;
  localparam logic [31:0] IDX_PIN_CTL   = 32'hfffff592;
  localparam logic [31:0] IDX_EDGE_CTL  = 32'hfffff594;
  localparam logic [31:0] IDX_OPTION    = 32'hfffff595;
  localparam logic [31:0] IDX_COUNT     = 32'hfffff596;
  localparam logic [31:0] IDX_CYCLE_LEN = 32'hfffff597;
  localparam logic [31:0] ADDR_RUN_CTL   = {IDX_RUN_CTL[29:0], 2'b00};
  localparam logic [31:0] ADDR_MODE_CTL  = {IDX_MODE_CTL[29:0], 2'b00};
  localparam logic [31:0] ADDR_PIN_CTL   = {IDX_PIN_CTL[29:0], 2'b00};
  localparam logic [31:0] ADDR_EDGE_CTL  = {IDX_EDGE_CTL[29:0], 2'b00};
  localparam logic [31:0] ADDR_OPTION    = {IDX_OPTION[29:0], 2'b00};
  localparam logic [31:0] ADDR_COUNT     = {IDX_COUNT[29:0], 2'b00};
  localparam logic [31:0] ADDR_CYCLE_LEN = {IDX_CYCLE_LEN[29:0], 2'b00};

  localparam logic [7:0]  CTL_RST       = 8'h00;
  localparam logic [7:0]  RUN_CTL_MASK  = 8'h87;
  localparam logic [7:0]  MODE_CTL_MASK = 8'ha7;
  localparam logic [7:0]  PIN_CTL_MASK  = 8'h0f;
  localparam logic [7:0]  EDGE_CTL_MASK = 8'h0f;
  localparam logic [15:0] CNT_IDLE      = 16'hffff;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;
  localparam logic [15:0] CYCLE_LEN_RST = 16'h00ff;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  localparam int BIT_RUN     = 7;
  localparam int CKS_MSB     = 2;
  localparam int CKS_LSB     = 0;
  localparam logic [2:0] CKS_LAST = 3'b111;
  localparam int BIT_SYNC    = 7;
  localparam int BIT_SW_TRIG = 6;
  localparam int BIT_SRC     = 5;
  localparam int MODE_MSB    = 2;
  localparam int MODE_LSB    = 0;
  localparam int BIT_A_EN    = 0;
  localparam int BIT_A_LVL   = 1;
  localparam int BIT_B_EN    = 2;
  localparam int BIT_B_LVL   = 3;
  localparam int EV_SEL_MSB  = 3;
  localparam int EV_SEL_LSB  = 2;
  localparam int TRG_SEL_MSB = 1;
  localparam int TRG_SEL_LSB = 0;
  localparam int BIT_OVF     = 0;
  localparam int PRESC_W     = 7;

endpackage

/* File: logic/tmc_timer.sv */
`timescale 1ns/10ps
module tmc_timer
  import tmc_pkg::*;
#(
  parameter bit ODD_CHANNEL = 1'b0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire tmc_axi_req_t axi_req,
  output tmc_axi_rsp_t      axi_rsp,
  input  wire logic         trigger_event_input,
  input  wire logic         subclock_in,
  input  wire logic         sync_tick_in,
  input  wire logic         sync_clear_in,
  output logic              sync_tick_out,
  output logic              sync_clear_out,
  output logic              timer_output_a,
  output logic              timer_output_b
);

  typedef enum logic [1:0] {
    PULSE_IDLE   = 2'b00,
    PULSE_ACTIVE = 2'b01
  } tmc_pulse_t;

  typedef struct packed {
    logic [7:0]         run_ctl;
    logic [7:0]         mode_ctl;
    logic [7:0]         pin_ctl;
    logic [7:0]         edge_ctl;
    logic [15:0]        cycle_len;
    logic               overflow_flag;
    logic [15:0]        count;
    logic [PRESC_W-1:0] presc;
    logic               started;
    logic               wave;
    tmc_pulse_t         pulse;
    logic               pin_meta;
    logic               pin_sync;
    logic               sub_meta;
    logic               sub_sync;
    logic               out_a;
    logic               out_b;
    logic               tick_out;
    logic               clear_out;
    logic               aw_got;
    logic               w_got;
    logic [31:0]        aw_addr;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } tmc_state_t;

  localparam tmc_state_t STATE_RST = '{
    run_ctl:   CTL_RST,
    mode_ctl:  CTL_RST,
    pin_ctl:   CTL_RST,
    edge_ctl:  CTL_RST,
    cycle_len: CYCLE_LEN_RST,
    count:     CNT_IDLE,
    pulse:     PULSE_IDLE,
    bresp:     RESP_OKAY,
    rresp:     RESP_OKAY,
    default:   '0
  };

  tmc_state_t         state_q;
  tmc_state_t         state_d;
  logic               awready;
  logic               wready;
  logic               arready;
  logic               event_hit;
  logic               trig_hit;
  logic               sub_hit;
  logic               sw_trig;
  logic               ovf_set;
  logic               ovf_clr;
  logic               run;
  logic               slave;
  logic               ext_src;
  logic               int_tick;
  logic               tick;
  logic               trig_mode;
  logic               trig_any;
  logic               wrap;
  logic [15:0]        half;
  logic [15:0]        cnt_inc;
  logic [PRESC_W-1:0] presc_mask;
  logic [2:0]         cks;
  tmc_mode_t          mode;

  // external pin and subclock each pass two flops first
  tmc_edge_det u_event_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .level   (state_q.pin_sync),
    .sel     (tmc_edge_t'(state_q.edge_ctl[EV_SEL_MSB:EV_SEL_LSB])),
    .hit     (event_hit)
  );

  tmc_edge_det u_trig_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .level   (state_q.pin_sync),
    .sel     (tmc_edge_t'(state_q.edge_ctl[TRG_SEL_MSB:TRG_SEL_LSB])),
    .hit     (trig_hit)
  );

  tmc_edge_det u_sub_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .level   (state_q.sub_sync),
    .sel     (EDGE_RISE),
    .hit     (sub_hit)
  );

  // handshakes only on enabled edges, else frozen state would lose them
  assign awready = ce & ~state_q.aw_got & ~state_q.bvalid;
  assign wready  = ce & ~state_q.w_got & ~state_q.bvalid;
  assign arready = ce & ~state_q.rvalid;

  always_comb begin
    run        = state_q.run_ctl[BIT_RUN];
    slave      = state_q.mode_ctl[BIT_SYNC];
    mode       = tmc_mode_t'(state_q.mode_ctl[MODE_MSB:MODE_LSB]);
    cks        = state_q.run_ctl[CKS_MSB:CKS_LSB];
    presc_mask = PRESC_W'((8'h01 << cks) - 8'h01);
    int_tick   = &(state_q.presc | ~presc_mask);
    if (ODD_CHANNEL && cks == CKS_LAST) begin
      int_tick = sub_hit;
    end
    ext_src = state_q.mode_ctl[BIT_SRC] | (mode == MODE_EVENT_COUNT);
    if (slave) begin
      tick = sync_tick_in;
    end else if (ext_src) begin
      tick = event_hit;
    end else begin
      tick = int_tick;
    end
    trig_mode = (mode == MODE_EXT_TRIG) || (mode == MODE_ONE_SHOT);
    wrap      = state_q.count == state_q.cycle_len;
    half      = state_q.cycle_len >> 1;
    cnt_inc   = state_q.count + 16'h0001;
  end

  always_comb begin
    state_d           = state_q;
    sw_trig           = 1'b0;
    ovf_set           = 1'b0;
    ovf_clr           = 1'b0;
    trig_any          = 1'b0;
    state_d.pin_meta  = trigger_event_input;
    state_d.pin_sync  = state_q.pin_meta;
    state_d.sub_meta  = subclock_in;
    state_d.sub_sync  = state_q.sub_meta;
    state_d.tick_out  = 1'b0;
    state_d.clear_out = 1'b0;

    // write channel: address and data in either order
    if (axi_req.awvalid && awready) begin
      state_d.aw_got  = 1'b1;
      state_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && wready) begin
      state_d.w_got  = 1'b1;
      state_d.w_data = axi_req.wdata;
      state_d.w_strb = axi_req.wstrb;
    end
    if (state_q.bvalid && axi_req.bready) begin
      state_d.bvalid = 1'b0;
    end
    if (state_q.aw_got && state_q.w_got) begin
      state_d.aw_got = 1'b0;
      state_d.w_got  = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp  = RESP_OKAY;
      case (state_q.aw_addr)
        ADDR_RUN_CTL: if (state_q.w_strb[0]) begin
          state_d.run_ctl = state_q.w_data[7:0] & RUN_CTL_MASK;
        end
        ADDR_MODE_CTL: if (state_q.w_strb[0]) begin
          state_d.mode_ctl = state_q.w_data[7:0] & MODE_CTL_MASK;
          sw_trig          = state_q.w_data[BIT_SW_TRIG];
        end
        ADDR_PIN_CTL: if (state_q.w_strb[0]) begin
          state_d.pin_ctl = state_q.w_data[7:0] & PIN_CTL_MASK;
        end
        ADDR_EDGE_CTL: if (state_q.w_strb[0]) begin
          state_d.edge_ctl = state_q.w_data[7:0] & EDGE_CTL_MASK;
        end
        ADDR_OPTION: if (state_q.w_strb[0]) begin
          ovf_clr = ~state_q.w_data[BIT_OVF];
        end
        ADDR_CYCLE_LEN: begin
          if (state_q.w_strb[0]) begin
            state_d.cycle_len[7:0] = state_q.w_data[7:0];
          end
          if (state_q.w_strb[1]) begin
            state_d.cycle_len[15:8] = state_q.w_data[15:8];
          end
        end
        ADDR_COUNT: state_d.bresp = RESP_OKAY;
        default: state_d.bresp = RESP_SLVERR;
      endcase
    end

    // read channel
    if (state_q.rvalid && axi_req.rready) begin
      state_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && arready) begin
      state_d.rvalid = 1'b1;
      state_d.rresp  = RESP_OKAY;
      state_d.rdata  = '0;
      case (axi_req.araddr)
        ADDR_RUN_CTL:   state_d.rdata[7:0] = state_q.run_ctl;
        ADDR_MODE_CTL:  state_d.rdata[7:0] = state_q.mode_ctl;
        ADDR_PIN_CTL:   state_d.rdata[7:0] = state_q.pin_ctl;
        ADDR_EDGE_CTL:  state_d.rdata[7:0] = state_q.edge_ctl;
        ADDR_OPTION:    state_d.rdata[BIT_OVF] = state_q.overflow_flag;
        ADDR_COUNT:     state_d.rdata[15:0] = run ? state_q.count : CNT_ZERO;
        ADDR_CYCLE_LEN: state_d.rdata[15:0] = state_q.cycle_len;
        default:        state_d.rresp = RESP_SLVERR;
      endcase
    end

    // trigger from pin edge or software strobe, only in trigger modes
    trig_any = run && trig_mode && (trig_hit || sw_trig);

    if (!run) begin
      state_d.count   = CNT_IDLE;
      state_d.presc   = '0;
      state_d.started = 1'b0;
      state_d.wave    = 1'b0;
      state_d.pulse   = PULSE_IDLE;
    end else begin
      state_d.presc = state_q.presc + PRESC_W'(1);
      if (tick) begin
        state_d.started  = 1'b1;
        state_d.tick_out = 1'b1;
      end
      unique case (mode)
        MODE_FREE_RUN, MODE_PULSE_WIDTH: if (tick) begin
          state_d.count = cnt_inc;
          ovf_set       = state_q.started && (state_q.count == CNT_IDLE);
          if (wrap) begin
            state_d.wave = ~state_q.wave;
          end
        end
        MODE_EXT_TRIG, MODE_ONE_SHOT: begin
          unique case (state_q.pulse)
            PULSE_IDLE: if (trig_any) begin
              state_d.pulse     = PULSE_ACTIVE;
              state_d.count     = CNT_ZERO;
              state_d.wave      = 1'b1;
              state_d.clear_out = 1'b1;
            end
            PULSE_ACTIVE: begin
              if (trig_any && mode == MODE_EXT_TRIG) begin
                state_d.count     = CNT_ZERO;
                state_d.wave      = 1'b1;
                state_d.clear_out = 1'b1;
              end else if (tick && wrap) begin
                if (mode == MODE_ONE_SHOT) begin
                  state_d.pulse = PULSE_IDLE;
                  state_d.wave  = 1'b0;
                end else begin
                  state_d.count     = CNT_ZERO;
                  state_d.wave      = 1'b1;
                  state_d.clear_out = 1'b1;
                end
              end else if (tick) begin
                state_d.count = cnt_inc;
                if (mode == MODE_EXT_TRIG) begin
                  state_d.wave = cnt_inc < half;
                end
              end
            end
            default: state_d.pulse = PULSE_IDLE;
          endcase
        end
        MODE_PWM: if (tick) begin
          state_d.count = wrap ? CNT_ZERO : cnt_inc;
          state_d.wave  = (wrap ? CNT_ZERO : cnt_inc) < half;
          state_d.clear_out = wrap;
        end
        // interval, event count and the prohibited code share this path
        default: if (tick) begin
          state_d.count     = wrap ? CNT_ZERO : cnt_inc;
          state_d.clear_out = wrap;
          if (wrap) begin
            state_d.wave = ~state_q.wave;
          end
        end
      endcase
      if (slave && sync_clear_in) begin
        state_d.count = CNT_ZERO;
      end
    end

    // set wins over a software clear in the same cycle
    state_d.overflow_flag = run & (ovf_set | (state_q.overflow_flag & ~ovf_clr));

    // pins follow new control bits on the same edge the write lands
    state_d.out_a = state_d.pin_ctl[BIT_A_EN] ?
                    (state_d.wave ? state_d.pin_ctl[BIT_A_LVL] : ~state_d.pin_ctl[BIT_A_LVL])
                  : state_d.pin_ctl[BIT_A_LVL];
    state_d.out_b = state_d.pin_ctl[BIT_B_EN] ?
                    (state_d.wave ? state_d.pin_ctl[BIT_B_LVL] : ~state_d.pin_ctl[BIT_B_LVL])
                  : state_d.pin_ctl[BIT_B_LVL];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= STATE_RST;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_comb begin
    axi_rsp.awready = awready;
    axi_rsp.wready  = wready;
    axi_rsp.bvalid  = ce & state_q.bvalid;
    axi_rsp.bresp   = state_q.bresp;
    axi_rsp.arready = arready;
    axi_rsp.rvalid  = ce & state_q.rvalid;
    axi_rsp.rdata   = state_q.rdata;
    axi_rsp.rresp   = state_q.rresp;
  end

  assign sync_tick_out  = state_q.tick_out;
  assign sync_clear_out = state_q.clear_out;
  assign timer_output_a = state_q.out_a;
  assign timer_output_b = state_q.out_b;

endmodule

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import tmc_pkg::*;
  logic         aclk;
  logic         aresetn;
  logic         ce;
  tmc_axi_req_t req;
  tmc_axi_rsp_t rsp;
  logic         pin_in;
  logic         sub_clk;
  logic         out_a;
  logic         out_b;
  int           error_cnt;
  int           check_count;
  logic [31:0]  rd_q;
  logic [31:0]  v;
  logic [1:0]   resp_q;
  logic [15:0]  cnt_q;
  logic         sync_tick;
  logic         sync_clr;
  logic         tick_out;
  logic         clr_out;
  int           clr_seen = 0;
  logic [2:0]   modes [5] = '{3'b000, 3'b001, 3'b100, 3'b101, 3'b110};

  // odd channel, so the last clock select picks the subclock
  tmc_timer #(.ODD_CHANNEL(1'b1)) tmc_timer_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(req), .axi_rsp(rsp),
    .trigger_event_input(pin_in), .subclock_in(sub_clk), .sync_tick_in(sync_tick),
    .sync_clear_in(sync_clr), .sync_tick_out(tick_out), .sync_clear_out(clr_out),
    .timer_output_a(out_a), .timer_output_b(out_b)
  );
  tmc_pin_model tmc_pin_model_inst (
    .aclk(aclk), .trigger_event_input(pin_in), .subclock_in(sub_clk)
  );

  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  // counts period restarts seen on the clear output
  always @(negedge aclk) begin
    if (clr_out === 1'b1) clr_seen++;
  end

  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // handshakes judged at the falling edge, released after the taking edge;
  // each call starts on its own edge, and ready rises only once the answer
  // shows, so the slave must hold its response for a cycle
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic b;
    logic bv;
    int   n;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    b = 1'b0;
    n = 0;
    while (b !== 1'b1 && n < 200) begin
      @(negedge aclk);
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      b = req.bready && rsp.bvalid;
      bv = rsp.bvalid;
      resp_q = rsp.bresp;
      @(posedge aclk);
      if (aw === 1'b1) req.awvalid <= 1'b0;
      if (w === 1'b1) req.wvalid <= 1'b0;
      if (b === 1'b1) req.bready <= 1'b0;
      else if (bv === 1'b1) req.bready <= 1'b1;
      n++;
    end
    if (b !== 1'b1) error_cnt++;
  endtask

  task automatic rd(input logic [31:0] a);
    logic ar;
    logic r;
    logic rv;
    int   n;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    r = 1'b0;
    n = 0;
    while (r !== 1'b1 && n < 200) begin
      @(negedge aclk);
      ar = req.arvalid && rsp.arready;
      r = req.rready && rsp.rvalid;
      rv = rsp.rvalid;
      rd_q = rsp.rdata;
      resp_q = rsp.rresp;
      @(posedge aclk);
      if (ar === 1'b1) req.arvalid <= 1'b0;
      if (r === 1'b1) req.rready <= 1'b0;
      else if (rv === 1'b1) req.rready <= 1'b1;
      n++;
    end
    if (r !== 1'b1) error_cnt++;
  endtask

  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    sync_tick = 1'b0;
    sync_clr = 1'b0;
    req = '0;
    req.wstrb = 4'hf;
    error_cnt = 0;
    check_count = 0;
    cyc(8);
    aresetn <= 1'b1;
    cyc(1);
    rd(ADDR_MODE_CTL);
    chk(rd_q, 32'h00);
    rd(ADDR_PIN_CTL);
    chk(rd_q, 32'h00);
    chk({31'h0, out_a}, 32'h0);
    wr(ADDR_MODE_CTL, 32'he6);
    rd(ADDR_MODE_CTL);
    chk(rd_q, 32'ha6);
    req.wstrb <= 4'h0;
    wr(ADDR_MODE_CTL, 32'h00);
    req.wstrb <= 4'hf;
    rd(ADDR_MODE_CTL);
    chk(rd_q, 32'ha6);
    wr(ADDR_MODE_CTL, 32'h00);
    wr(32'hffffd64c, 32'h5a);
    chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
    rd(32'hffffd64c);
    chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
    chk(rd_q, 32'h0);
    for (int i = 0; i < 16; i++) begin
      v = 32'(i);
      wr(ADDR_PIN_CTL, v);
      chk({31'h0, out_a}, {31'h0, v[0] ^ v[1]});
      chk({31'h0, out_b}, {31'h0, v[2] ^ v[3]});
      rd(ADDR_PIN_CTL);
      chk(rd_q, v);
    end
    wr(ADDR_PIN_CTL, 32'h00);
    wr(ADDR_EDGE_CTL, 32'h04);
    wr(ADDR_MODE_CTL, 32'h01);
    wr(ADDR_RUN_CTL, 32'h80);
    tmc_pin_model_inst.pulses(5);
    cyc(6);
    rd(ADDR_COUNT);
    chk(rd_q, 32'h4);
    wr(ADDR_RUN_CTL, 32'h00);
    wr(ADDR_MODE_CTL, 32'h20);
    wr(ADDR_RUN_CTL, 32'h80);
    tmc_pin_model_inst.pulses(3);
    cyc(6);
    rd(ADDR_COUNT);
    chk(rd_q, 32'h2);
    wr(ADDR_RUN_CTL, 32'h00);
    rd(ADDR_COUNT);
    chk(rd_q, 32'h0);
    wr(ADDR_EDGE_CTL, 32'h00);
    wr(ADDR_PIN_CTL, 32'h01);
    for (int i = 2; i < 4; i++) begin
      wr(ADDR_RUN_CTL, 32'h00);
      wr(ADDR_MODE_CTL, 32'(i));
      wr(ADDR_RUN_CTL, 32'h80);
      chk({31'h0, out_a}, 32'h1);
      wr(ADDR_MODE_CTL, 32'h40 | 32'(i));
      cyc(3);
      chk({31'h0, out_a}, 32'h0);
      rd(ADDR_MODE_CTL);
      chk(rd_q, 32'(i));
    end
    chk(32'(clr_seen), 32'h2);
    cyc(300);
    chk({31'h0, out_a}, 32'h1);
    foreach (modes[k]) begin
      wr(ADDR_RUN_CTL, 32'h00);
      wr(ADDR_MODE_CTL, 32'(modes[k]));
      wr(ADDR_RUN_CTL, 32'h80);
      cyc(40);
      rd(ADDR_COUNT);
      cnt_q = rd_q[15:0];
      wr(ADDR_MODE_CTL, 32'h40 | 32'(modes[k]));
      rd(ADDR_COUNT);
      chk(32'(rd_q[15:0] >= cnt_q), 32'h1);
    end
    wr(ADDR_RUN_CTL, 32'h00);
    wr(ADDR_MODE_CTL, 32'h80);
    wr(ADDR_RUN_CTL, 32'h80);
    cyc(10);
    rd(ADDR_COUNT);
    chk(rd_q, 32'hffff);
    repeat (3) begin
      sync_tick <= 1'b1;
      cyc(1);
      sync_tick <= 1'b0;
      @(negedge aclk);
      chk({31'h0, tick_out}, 32'h1);
      cyc(1);
    end
    rd(ADDR_COUNT);
    chk(rd_q, 32'h2);
    sync_clr <= 1'b1;
    cyc(1);
    sync_clr <= 1'b0;
    rd(ADDR_COUNT);
    chk(rd_q, 32'h0);
    wr(ADDR_RUN_CTL, 32'h00);
    wr(ADDR_MODE_CTL, 32'h00);
    wr(ADDR_RUN_CTL, 32'h87);
    cyc(100);
    rd(ADDR_COUNT);
    chk(32'(rd_q[15:0] == 16'h2 || rd_q[15:0] == 16'h3), 32'h1);
    wr(ADDR_RUN_CTL, 32'h00);
    end_of_test;
  end

  initial begin
    cyc(20000);
    error_cnt++;
    end_of_test;
  end
endmodule

/* File: verification/tmc_pin_model.sv */
`timescale 1ns/10ps
module tmc_pin_model (
  input  wire logic aclk,
  output logic      trigger_event_input,
  output logic      subclock_in
);
  initial begin
    trigger_event_input = 1'b0;
    subclock_in = 1'b0;
  end

  // subclock oscillator runs free, slow against the main clock
  always begin
    repeat (16) @(posedge aclk);
    subclock_in <= ~subclock_in;
  end

  // each pulse gives one rising edge, held past the input synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      trigger_event_input <= 1'b1;
      repeat (4) @(posedge aclk);
      trigger_event_input <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule

/* File: verification/tmc_timer_properties.sv */
`timescale 1ns/10ps
module tmc_timer_properties
  import tmc_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         ce,
  input wire tmc_axi_req_t axi_req,
  input wire tmc_axi_rsp_t axi_rsp,
  input wire logic         trigger_event_input,
  input wire logic         subclock_in,
  input wire logic         sync_tick_in,
  input wire logic         sync_clear_in,
  input wire logic         sync_tick_out,
  input wire logic         sync_clear_out,
  input wire logic         timer_output_a,
  input wire logic         timer_output_b
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [31:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [31:0] rd_addr_q;
  logic        wr_lane_q;
  logic        run_q;

  // shadow of the last write and the run bit, to know what the pins should show
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr_q <= '0;
      wr_data_q <= '0;
      rd_addr_q <= '0;
      wr_lane_q <= 1'b0;
      run_q     <= 1'b0;
    end else if (ce) begin
      if (axi_req.awvalid && axi_rsp.awready) wr_addr_q <= axi_req.awaddr;
      if (axi_req.wvalid && axi_rsp.wready) begin
        wr_data_q <= axi_req.wdata;
        wr_lane_q <= axi_req.wstrb[0];
      end
      if (axi_req.arvalid && axi_rsp.arready) rd_addr_q <= axi_req.araddr;
      if ($rose(axi_rsp.bvalid) && wr_addr_q == ADDR_RUN_CTL && wr_lane_q) begin
        run_q <= wr_data_q[BIT_RUN];
      end
    end
  end

  sequence wr_both;
    ce && axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence pin_lands;
    $rose(axi_rsp.bvalid) && wr_addr_q == ADDR_PIN_CTL && wr_lane_q && !run_q
      && axi_rsp.bresp == RESP_OKAY;
  endsequence

  write_answer_a: assert property (wr_both |-> ##2 axi_rsp.bvalid)
    else $error("write response missing");
  read_answer_a: assert property (ce && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read response missing");
  wresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=>
      axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
    else $error("read data dropped");
  read_refuse_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while busy");
  reset_pins_a: assert property ($rose(aresetn) |-> !timer_output_a && !timer_output_b)
    else $error("pins not low after reset");
  mode_readback_a: assert property (axi_rsp.rvalid && rd_addr_q == ADDR_MODE_CTL |->
      axi_rsp.rdata[31:8] == '0 && !axi_rsp.rdata[6] && axi_rsp.rdata[4:3] == 2'b00)
    else $error("mode control reserved bits set");
  pin_readback_a: assert property (axi_rsp.rvalid && rd_addr_q == ADDR_PIN_CTL |->
      axi_rsp.rdata[31:4] == '0)
    else $error("pin control upper bits set");
  error_data_a: assert property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR |->
      axi_rsp.rdata == '0)
    else $error("error read carries data");
  stopped_pins_a: assert property (pin_lands |->
      timer_output_a == (wr_data_q[BIT_A_EN] ^ wr_data_q[BIT_A_LVL])
      && timer_output_b == (wr_data_q[BIT_B_EN] ^ wr_data_q[BIT_B_LVL]))
    else $error("pin level wrong after stopped write");
endmodule

bind tmc_timer tmc_timer_properties tmc_timer_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .trigger_event_input(trigger_event_input), .subclock_in(subclock_in),
  .sync_tick_in(sync_tick_in), .sync_clear_in(sync_clear_in), .sync_tick_out(sync_tick_out),
  .sync_clear_out(sync_clear_out), .timer_output_a(timer_output_a),
  .timer_output_b(timer_output_b)
);
